// >>> serial_tx_mode_control.sv
// Purpose: Mode control and transmit path of one serial channel
// Assumes: Register port on core_clk, serial clock pin sampled by core_clk
// Notes:   Rules follow
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module serial_tx_mode_control #(
    parameter int SCLK_HALF = serial_tx_pkg::SCLK_HALF_CYC,
    parameter int BAUD_DIV  = serial_tx_pkg::BAUD_CYC,
    parameter int FIFO_D    = 16
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        idle_mode,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    input  wire logic        sclk_in,
    output logic             sclk_out,
    output logic             sclk_oe,
    output logic             txd,
    output logic             rx_allow,
    output logic             tx_space
);
    // ************************************************************
    // Registers
    // ************************************************************
    serial_tx_pkg::mode_one_t   mode_one_reg;
    serial_tx_pkg::mode_zero_t  mode_zero_reg;
    serial_tx_pkg::tx_state_t   state_reg;
    logic                       tbemp_reg;
    logic [serial_tx_pkg::FRAME_W-1:0] shift_reg;
    logic [3:0]                 bits_left_reg;
    logic [6:0]                 gap_cnt_reg;
    logic [15:0]                div_reg;
    logic                       phase_reg;
    logic                       sclk_d_reg;
    logic                       sclk_s;
    logic                       active;
    logic                       is_sync;
    logic                       drive_sclk;
    logic                       tx_permit;
    logic                       shift_pulse;
    logic                       end_pulse;
    logic                       div_wrap;
    logic                       word_done;
    logic                       want_gap;
    logic                       fifo_in_ready;
    logic                       fifo_valid;
    logic                       fifo_pop;
    logic [serial_tx_pkg::DATA_W-1:0] fifo_data;
    logic [6:0]                 gap_len;
    logic                       data_wr;

    assign is_sync    = (mode_zero_reg.transfer_mode_select == serial_tx_pkg::MODE_SYNC);
    assign drive_sclk = is_sync && mode_zero_reg.sclk_drive_select;
    assign active     = ce && !(idle_mode && !mode_one_reg.idle_run_select);
    assign tx_permit  = mode_one_reg.transmit_enable &&
                        (!is_sync || mode_one_reg.duplex_select[1]);
    assign data_wr    = ce && wr_en && (addr == serial_tx_pkg::OFS_TX_DATA);
    assign gap_len    = 7'(1) << (mode_one_reg.word_gap_interval - 3'(1));
    assign want_gap   = drive_sclk &&
                        (mode_one_reg.word_gap_interval != serial_tx_pkg::GAP_NONE);

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_one_reg <= serial_tx_pkg::MODE_ONE_RESET;
        end else if (ce && wr_en && addr == serial_tx_pkg::OFS_MODE_CTRL_ONE) begin
            mode_one_reg <= wr_data[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_zero_reg <= serial_tx_pkg::MODE_ZERO_RESET;
        end else if (ce && wr_en && addr == serial_tx_pkg::OFS_MODE_CTRL_ZERO) begin
            mode_zero_reg <= {wr_data[serial_tx_pkg::MODE_HI:serial_tx_pkg::MODE_LO],
                              wr_data[serial_tx_pkg::SCLK_OUT_BIT]};
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= '0;
            if (rd_en) begin
                unique case (addr)
                    serial_tx_pkg::OFS_MODE_CTRL_ZERO: begin
                        rd_data[serial_tx_pkg::MODE_HI:serial_tx_pkg::MODE_LO] <=
                            mode_zero_reg.transfer_mode_select;
                        rd_data[serial_tx_pkg::SCLK_OUT_BIT] <= mode_zero_reg.sclk_drive_select;
                    end
                    serial_tx_pkg::OFS_MODE_CTRL_ONE: begin
                        rd_data[7:0] <= mode_one_reg;
                    end
                    serial_tx_pkg::OFS_MODE_CTRL_TWO: begin
                        rd_data[serial_tx_pkg::TBEMP_BIT]  <= tbemp_reg;
                        rd_data[serial_tx_pkg::TXRUN_BIT]  <= (state_reg != serial_tx_pkg::ST_IDLE);
                        rd_data[serial_tx_pkg::TXFULL_BIT] <= !fifo_in_ready;
                    end
                    default: begin
                        rd_data <= '0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Buffer and status
    // ************************************************************
    word_fifo #(
        .WIDTH (serial_tx_pkg::DATA_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (data_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_data[serial_tx_pkg::DATA_W-1:0]),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tbemp_reg <= 1'b1;
            tx_space  <= 1'b1;
        end else if (ce) begin
            tbemp_reg <= data_wr ? 1'b0 : !fifo_valid;
            tx_space  <= fifo_in_ready;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_allow <= 1'b0;
        end else if (ce) begin
            rx_allow <= is_sync ? mode_one_reg.duplex_select[0] : 1'b1;
        end
    end

    // ************************************************************
    // Bit timing
    // ************************************************************
    bit_sync #(
        .WIDTH (1)
    ) u_sclk_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .async_in (sclk_in),
        .sync_out (sclk_s)
    );

    assign div_wrap = (div_reg == 16'(is_sync ? SCLK_HALF - 1 : BAUD_DIV - 1));

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg    <= '0;
            phase_reg  <= 1'b1;
            sclk_d_reg <= 1'b1;
        end else if (active) begin
            div_reg    <= div_wrap ? '0 : div_reg + 16'(1);
            sclk_d_reg <= sclk_s;
            if (div_wrap && is_sync) begin
                phase_reg <= !phase_reg;
            end
        end
    end

    always_comb begin
        shift_pulse = 1'b0;
        end_pulse   = 1'b0;
        if (!is_sync) begin
            shift_pulse = div_wrap;
            end_pulse   = div_wrap;
        end else if (drive_sclk) begin
            shift_pulse = div_wrap && phase_reg;
            end_pulse   = div_wrap && !phase_reg;
        end else begin
            shift_pulse = sclk_d_reg && !sclk_s;
            end_pulse   = !sclk_d_reg && sclk_s;
        end
    end

    // ************************************************************
    // Transmit sequencer
    // ************************************************************
    assign word_done = (state_reg == serial_tx_pkg::ST_SHIFT) && bits_left_reg == '0 &&
                       end_pulse;
    assign fifo_pop  = active && tx_permit && fifo_valid && shift_pulse &&
                       (state_reg == serial_tx_pkg::ST_IDLE);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg     <= serial_tx_pkg::ST_IDLE;
            shift_reg     <= '1;
            bits_left_reg <= '0;
            gap_cnt_reg   <= '0;
        end else if (active) begin
            unique case (state_reg)
                serial_tx_pkg::ST_IDLE: begin
                    if (fifo_pop) begin
                        state_reg <= serial_tx_pkg::ST_SHIFT;
                        unique case (mode_zero_reg.transfer_mode_select)
                            serial_tx_pkg::MODE_SYNC: begin
                                shift_reg     <= {4'hF, fifo_data[7:0]};
                                bits_left_reg <= serial_tx_pkg::LEN_SYNC;
                            end
                            serial_tx_pkg::MODE_UART7: begin
                                shift_reg     <= {4'hF, fifo_data[6:0], 1'b0};
                                bits_left_reg <= serial_tx_pkg::LEN_UART7;
                            end
                            serial_tx_pkg::MODE_UART8: begin
                                shift_reg     <= {3'h7, fifo_data[7:0], 1'b0};
                                bits_left_reg <= serial_tx_pkg::LEN_UART8;
                            end
                            serial_tx_pkg::MODE_UART9: begin
                                shift_reg     <= {2'h3, fifo_data[8:0], 1'b0};
                                bits_left_reg <= serial_tx_pkg::LEN_UART9;
                            end
                        endcase
                    end
                end
                serial_tx_pkg::ST_SHIFT: begin
                    if (shift_pulse && bits_left_reg != '0) begin
                        shift_reg     <= {1'b1, shift_reg[serial_tx_pkg::FRAME_W-1:1]};
                        bits_left_reg <= bits_left_reg - 4'(1);
                    end else if (word_done) begin
                        if (want_gap && fifo_valid && tx_permit) begin
                            state_reg   <= serial_tx_pkg::ST_GAP;
                            gap_cnt_reg <= gap_len;
                        end else begin
                            state_reg <= serial_tx_pkg::ST_IDLE;
                        end
                    end
                end
                serial_tx_pkg::ST_GAP: begin
                    if (end_pulse) begin
                        gap_cnt_reg <= gap_cnt_reg - 7'(1);
                        if (gap_cnt_reg == 7'(1)) begin
                            state_reg <= serial_tx_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= serial_tx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txd      <= 1'b1;
            sclk_out <= 1'b1;
            sclk_oe  <= 1'b0;
        end else if (active) begin
            sclk_oe <= drive_sclk;
            if (state_reg == serial_tx_pkg::ST_SHIFT && shift_pulse && bits_left_reg != '0) begin
                txd <= shift_reg[0];
            end else if (state_reg == serial_tx_pkg::ST_IDLE) begin
                txd <= 1'b1;
            end
            sclk_out <= (state_reg == serial_tx_pkg::ST_SHIFT) ? !phase_reg : 1'b1;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_word_end;
        active && word_done && want_gap && fifo_valid && tx_permit;
    endsequence

    sequence s_gap_entry;
        state_reg == serial_tx_pkg::ST_GAP;
    endsequence

    property p_idle_stop;
        @(posedge core_clk) disable iff (sys_rst)
        (idle_mode && !mode_one_reg.idle_run_select) |=> $stable(txd) && $stable(state_reg);
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("channel ran in idle stop");

    property p_duplex_rx;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && is_sync) |=> rx_allow == $past(mode_one_reg.duplex_select[0]);
    endproperty
    a_duplex_rx: assert property (p_duplex_rx) else $error("receive allow wrong");

    property p_uart_ignores_duplex;
        @(posedge core_clk) disable iff (sys_rst)
        (fifo_valid && active && shift_pulse && !is_sync && mode_one_reg.transmit_enable &&
         state_reg == serial_tx_pkg::ST_IDLE) |=> state_reg == serial_tx_pkg::ST_SHIFT;
    endproperty
    a_uart_ignores_duplex: assert property (p_uart_ignores_duplex)
        else $error("uart start blocked");

    property p_tx_gate;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == serial_tx_pkg::ST_IDLE && !mode_one_reg.transmit_enable)
            |=> state_reg == serial_tx_pkg::ST_IDLE;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("started without enable");

    property p_gap_len;
        @(posedge core_clk) disable iff (sys_rst)
        s_word_end |=> s_gap_entry ##0
            (gap_cnt_reg == 7'(1) << ($past(mode_one_reg.word_gap_interval) - 3'(1)));
    endproperty
    a_gap_len: assert property (p_gap_len) else $error("gap length wrong");

    property p_gap_only_sync_out;
        @(posedge core_clk) disable iff (sys_rst)
        (state_reg == serial_tx_pkg::ST_GAP) |-> drive_sclk;
    endproperty
    a_gap_only_sync_out: assert property (p_gap_only_sync_out)
        else $error("gap outside clock output mode");

    property p_frame_len;
        @(posedge core_clk) disable iff (sys_rst)
        fifo_pop && mode_zero_reg.transfer_mode_select == serial_tx_pkg::MODE_UART8
            |=> bits_left_reg == serial_tx_pkg::LEN_UART8;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

    property p_tbemp_clear;
        @(posedge core_clk) disable iff (sys_rst)
        data_wr |=> !tbemp_reg ##1
            (!$past(ce) || $past(data_wr) || tbemp_reg == !$past(fifo_valid));
    endproperty
    a_tbemp_clear: assert property (p_tbemp_clear) else $error("empty flag wrong");

    property p_rsvd_readback;
        @(posedge core_clk) disable iff (sys_rst)
        (ce && rd_en && addr == serial_tx_pkg::OFS_MODE_CTRL_ONE)
            |=> rd_data[serial_tx_pkg::RSVD_BIT] == $past(mode_one_reg.reserved_bit);
    endproperty
    a_rsvd_readback: assert property (p_rsvd_readback) else $error("reserved bit lost");
endmodule

// >>> serial_tx_pkg.sv
// Purpose: Shared constants and types for the serial transmit mode control block
// Assumes: Byte addresses on the register port, 32-bit data
// Notes:   Register offsets and fields are named here only
package serial_tx_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_MODE_CTRL_ZERO = 8'h00;
    localparam logic [7:0] OFS_MODE_CTRL_ONE  = 8'h04;
    localparam logic [7:0] OFS_MODE_CTRL_TWO  = 8'h08;
    localparam logic [7:0] OFS_TX_DATA        = 8'h0C;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int IDLE_RUN_BIT     = 7;
    localparam int DUPLEX_HI        = 6;
    localparam int DUPLEX_LO        = 5;
    localparam int TX_ENABLE_BIT    = 4;
    localparam int GAP_HI           = 3;
    localparam int GAP_LO           = 1;
    localparam int RSVD_BIT         = 0;
    localparam int MODE_HI          = 3;
    localparam int MODE_LO          = 2;
    localparam int SCLK_OUT_BIT     = 0;
    localparam int TBEMP_BIT        = 7;
    localparam int TXRUN_BIT        = 5;
    localparam int TXFULL_BIT       = 0;
    localparam logic [7:0] MODE_ONE_RESET = 8'h00;
    localparam logic [2:0] MODE_ZERO_RESET = 3'h0;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [1:0] DPX_NONE = 2'h0;
    localparam logic [2:0] GAP_NONE = 3'h0;
    localparam int DATA_W     = 9;
    localparam int FRAME_W    = 12;
    localparam logic [3:0] LEN_SYNC  = 4'h8;
    localparam logic [3:0] LEN_UART7 = 4'h9;
    localparam logic [3:0] LEN_UART8 = 4'hA;
    localparam logic [3:0] LEN_UART9 = 4'hB;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ        = 25_000_000;
    localparam int SCLK_HZ       = 1_000_000;
    localparam int BAUD_HZ       = 115_200;
    localparam int SCLK_HALF_CYC = CLK_HZ / (2 * SCLK_HZ);
    localparam int BAUD_CYC      = CLK_HZ / BAUD_HZ;

    typedef enum logic [1:0] {
        MODE_SYNC  = 2'b00,
        MODE_UART7 = 2'b01,
        MODE_UART8 = 2'b10,
        MODE_UART9 = 2'b11
    } xfer_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP   = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic       idle_run_select;
        logic [1:0] duplex_select;
        logic       transmit_enable;
        logic [2:0] word_gap_interval;
        logic       reserved_bit;
    } mode_one_t;

    typedef struct packed {
        xfer_mode_t transfer_mode_select;
        logic       sclk_drive_select;
    } mode_zero_t;

endpackage

// >>> bit_sync.sv
// Purpose: Two-stage synchroniser for inputs from outside the clock domain
// Assumes: Asynchronous input, core clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// >>> word_fifo.sv
// Purpose: Transmit word FIFO with valid and ready on both sides
// Assumes: Power-of-two depth
// Notes:   Writes while full are refused through in_ready
`timescale 1ns/10ps
module word_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// >>> serial_peer.sv
// Purpose: Serial peer model on the link side
// Assumes: Clock pin idles high between frames
// Notes:   Link clock period 320 ns while run is high
`timescale 1ns/10ps
module serial_peer (
    input  wire logic run,
    input  wire logic sclk_out,
    input  wire logic sclk_oe,
    output logic      sclk_in
);
    logic line_clk;
    initial begin
        line_clk = 1'b1;
        forever begin
            #160;
            line_clk = run ? ~line_clk : 1'b1;
        end
    end
    // Pin level: the device's drive wins while enabled
    assign sclk_in = sclk_oe ? sclk_out : line_clk;
endmodule

// >>> serial_tx_mode_control_bench.sv
// Purpose: Self-checking bench for the serial transmit mode control
// Assumes: UART bit period of 4 core clocks
// Notes:   Table of mode rows, then hand-written transmit cases
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module serial_tx_mode_control_bench;
    typedef struct {logic [31:0] m0; logic [31:0] m1; logic [7:0] rb; logic rx; logic oe;} row_t;
    logic        core_clk, sys_rst, ce, idle_mode, wr_en, rd_en, run;
    logic [7:0]  addr;
    logic [31:0] wr_data, rd_data;
    logic        sclk_in, sclk_out, sclk_oe, txd, rx_allow, tx_space;
    int          miscompares, n_compared;
    row_t        rows[7] = '{'{0, 0, 8'h00, 0, 0}, '{0, 32'h21, 8'h21, 1, 0},
        '{0, 32'hC0, 8'hC0, 0, 0}, '{0, 32'hFFFFFF6E, 8'h6E, 1, 0},
        '{1, 32'h40, 8'h40, 0, 1}, '{8, 32'h0E, 8'h0E, 1, 0}, '{32'hD, 0, 8'h00, 1, 0}};
    serial_tx_mode_control #(.SCLK_HALF(2), .BAUD_DIV(4), .FIFO_D(16)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .idle_mode(idle_mode),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .txd(txd),
        .rx_allow(rx_allow), .tx_space(tx_space));
    serial_peer peer_u (.run(run), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .sclk_in(sclk_in));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic get_byte(input logic [7:0] exp);
        int n;
        logic [7:0] b;
        n = 0;
        while (txd !== 1'b0 && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        #80;
        `CHK(txd, 1'b0)
        for (int i = 0; i < 8; i++) begin
            #160;
            b[i] = txd;
        end
        #160;
        `CHK(b, exp)
        `CHK(txd, 1'b1)
    endtask
    task automatic sync_pair(input logic [2:0] code, output int gap);
        logic [7:0] b;
        time        t;
        wr(8'h04, 32'h40 | {28'h0, code, 1'b0});
        wr(8'h0C, 32'hA5);
        wr(8'h0C, 32'h3C);
        wr(8'h04, 32'h50 | {28'h0, code, 1'b0});
        for (int w = 0; w < 2; w++) begin
            for (int i = 0; i < 8; i++) begin
                @(posedge sclk_out);
                if (w == 1 && i == 0) gap = int'(($time - t) / 40);
                t = $time;
                b[i] = txd;
            end
            `CHK(b, w ? 8'h3C : 8'hA5)
        end
    endtask
    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        miscompares++;
        stop_test;
    end
    initial begin
        logic [31:0] d;
        int          g0, g3;
        {sys_rst, ce, idle_mode, wr_en, rd_en, run, addr, wr_data} = {6'b110000, 40'h0};
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(8'h04, d);
        `CHK(d, 32'h0)
        rd(8'h08, d);
        `CHK(d, 32'h80)
        rd(8'h10, d);
        `CHK(d, 32'h0)
        $display("test reset done");
        foreach (rows[i]) begin
            wr(8'h00, rows[i].m0);
            wr(8'h04, rows[i].m1);
            rd(8'h04, d);
            `CHK(d, {24'h0, rows[i].rb})
            `CHK(rx_allow, rows[i].rx)
            `CHK(sclk_oe, rows[i].oe)
        end
        $display("test mode rows done");
        wr(8'h00, 32'h8);
        wr(8'h04, 32'h0);
        wr(8'h0C, 32'h5A);
        rd(8'h08, d);
        `CHK(d, 32'h0)
        repeat (60) @(posedge core_clk);
        `CHK(txd, 1'b1)
        idle_mode <= 1'b1;
        wr(8'h04, 32'h10);
        repeat (60) @(posedge core_clk);
        `CHK(txd, 1'b1)
        idle_mode <= 1'b0;
        get_byte(8'h5A);
        $display("test gating done");
        wr(8'h04, 32'h0);
        for (int i = 0; i < 17; i++) wr(8'h0C, 32'h11 * i);
        rd(8'h08, d);
        `CHK(d, 32'h01)
        `CHK(tx_space, 1'b0)
        wr(8'h04, 32'h10);
        for (int i = 0; i < 16; i++) get_byte(8'(8'h11 * i));
        repeat (8) @(posedge core_clk);
        rd(8'h08, d);
        `CHK(d, 32'h80)
        `CHK(tx_space, 1'b1)
        $display("test fifo done");
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        sync_pair(3'h0, g0);
        sync_pair(3'h3, g3);
        `CHK(g3 - g0, 16)
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h20);
        wr(8'h0C, 32'hC3);
        wr(8'h04, 32'h30);
        run <= 1'b1;
        repeat (40) @(posedge core_clk);
        rd(8'h08, d);
        `CHK(d, 32'h0)
        run <= 1'b0;
        wr(8'h04, 32'h40);
        wr(8'h04, 32'h50);
        repeat (8) @(posedge core_clk);
        run <= 1'b1;
        @(posedge sclk_in);
        for (int i = 0; i < 8; i++) begin
            @(posedge sclk_in);
            d[i] = txd;
        end
        run <= 1'b0;
        `CHK(d[7:0], 8'hC3)
        $display("test sync done");
        stop_test;
    end
endmodule
